// *** hdl/flash_prot_defines.svh ***
// Constants of the flash access and protection block.
// Assumes one system clock and an including file that needs plain macros.
//
// Operation
// - The array holds 32 KB and is reached only through this access logic.
// - The array is split into 1 KB erase units that erase independently of each other.
// - After an erase every bit of the erased unit reads as one.
// - Protection is set per 2 KB region made of two adjacent erase units, each region on its own.
// - A read-only region refuses erase and program but still serves reads.
// - An execute-only region refuses erase and program and serves only instruction fetches that do not come from debug.
// - A permitted read completes in one clock cycle without wait states when no erase runs; during an erase it gets no answer.
`ifndef FLASH_PROT_DEFINES_SVH
`define FLASH_PROT_DEFINES_SVH

// ****************************************
// Geometry
// ****************************************
`define FLASH_BYTES       32768
`define FLASH_WORD_BITS   32
`define FLASH_ADDR_BITS   15
`define UNIT_SHIFT        10
`define REGION_SHIFT      11
`define REGION_COUNT      16
`define ERASED_WORD       32'hffffffff

// ****************************************
// Protection codes per region
// ****************************************
`define PROT_OPEN         2'h0
`define PROT_READ_ONLY    2'h1
`define PROT_EXEC_ONLY    2'h2

`endif

// *** hdl/flash_prot_pkg.sv ***
// Types shared by the flash access block.
// Assumes the defines header sits in the include path.
`include "flash_prot_defines.svh"

package flash_prot_pkg;

    // ****************************************
    // Request kinds and carrier
    // ****************************************
    typedef enum logic [3:0]
    {
        op_fetch   = 4'b0001,
        op_read    = 4'b0010,
        op_program = 4'b0100,
        op_erase   = 4'b1000
    } flash_op_type;

    typedef struct packed
    {
        logic                          valid;
        flash_op_type                  op;
        logic                          debug;
        logic [`FLASH_ADDR_BITS-1:0]   addr;
        logic [`FLASH_WORD_BITS-1:0]   wdata;
    } flash_req_type;

    typedef struct packed
    {
        logic                          done;
        logic                          refused;
        logic [`FLASH_WORD_BITS-1:0]   rdata;
    } flash_rsp_type;

endpackage

// *** hdl/flash_prot_check.sv ***
// Decides whether one request may touch the array.
// Assumes the protection map arrives as a flat vector, two bits per region.
`timescale 1ns/1ps
`include "flash_prot_defines.svh"

module flash_prot_check
    import flash_prot_pkg::*;
#(
    parameter int REGIONS = `REGION_COUNT
)
(
    // Request
    input  wire flash_req_type          req,
    // Protection map
    input  wire logic [2*REGIONS-1:0]   prot_map,
    // Verdict
    output logic                        allow
);

    logic [1:0] code;
    logic [3:0] region;

    // Region index from the upper address bits
    assign region = req.addr[`FLASH_ADDR_BITS-1:`REGION_SHIFT];
    assign code   = prot_map[{region, 1'b0} +: 2];

    // Verdict per protection code
    always_comb
    begin
        allow = 1'b1;
        case (code)
            `PROT_READ_ONLY: allow = (req.op == op_fetch) || (req.op == op_read);
            `PROT_EXEC_ONLY: allow = (req.op == op_fetch) && !req.debug;
            default:         allow = 1'b1;
        endcase
    end

endmodule // flash_prot_check

// *** hdl/flash_block_protection.sv ***
// Flash array with per-region protection and unit erase.
// Assumes one request per cycle from an arbiter in front of this block.
`timescale 1ns/1ps
`include "flash_prot_defines.svh"

module flash_block_protection
    import flash_prot_pkg::*;
#(
    parameter int REGIONS = `REGION_COUNT
)
(
    // Clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    // Access request and answer
    input  wire flash_req_type          req,
    output flash_rsp_type               rsp,
    // Protection settings and violation status
    input  wire logic [2*REGIONS-1:0]   prot_map,
    input  wire logic                   violation_clear,
    output logic                        violation_q
);

    // ****************************************
    // Geometry
    // ****************************************
    localparam int WORDS      = `FLASH_BYTES / 4;
    localparam int UNIT_WORDS = (1 << `UNIT_SHIFT) / 4;
    // Index of the last word in one erase unit
    localparam logic [7:0] LAST_IDX = 8'(UNIT_WORDS - 1);

    // ****************************************
    // Storage and decode signals
    // ****************************************
    // Array; no reset, so contents outlive a reset as the cells would
    logic [`FLASH_WORD_BITS-1:0] mem [WORDS];
    // Erase position: unit being erased and word inside it
    logic [7:0]                  erase_idx_q;
    logic [4:0]                  erase_unit_q;
    // Request decode
    logic [12:0]                 addr_word;
    logic                        allow;
    logic                        busy;
    logic                        take;
    logic                        refuse;
    logic                        erase_go;
    logic                        program_go;
    logic                        read_go;
    logic                        erase_last;
    // Answer flip-flops
    logic                        done_q;
    logic                        refused_q;
    logic [`FLASH_WORD_BITS-1:0] rdata_q;

    // One-hot sequencer states
    typedef enum logic [1:0]
    {
        st_idle  = 2'b01,
        st_erase = 2'b10
    } erase_state_type;
    erase_state_type state_q;

    // Fetch and data read are the two kinds that hand contents back
    function automatic logic returns_data(flash_op_type op);
        return (op == op_fetch) || (op == op_read);
    endfunction

    // ****************************************
    // Protection check
    // ****************************************
    // Combinational verdict, so a permitted read still completes in one cycle
    flash_prot_check #(.REGIONS(REGIONS)) u_check
    (
        .req      (req),
        .prot_map (prot_map),
        .allow    (allow)
    );

    // ****************************************
    // Request decode
    // ****************************************
    // Word address; the two byte bits are ignored
    assign addr_word  = req.addr[`FLASH_ADDR_BITS-1:2];
    // While an erase runs the bus is ignored and gets no answer at all
    assign busy       = (state_q == st_erase);
    assign take       = req.valid && !busy;
    // A taken request ends in exactly one outcome
    assign refuse     = take && !allow;
    assign erase_go   = take && allow && (req.op == op_erase);
    assign program_go = take && allow && (req.op == op_program);
    assign read_go    = take && allow && returns_data(req.op);
    // Last word of the unit is written on this edge
    assign erase_last = busy && (erase_idx_q == LAST_IDX);

    // ****************************************
    // Erase sequencer
    // ****************************************
    // One word per cycle keeps a single write port; requests are ignored meanwhile
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q      <= st_idle;
            erase_idx_q  <= 8'h00;
            erase_unit_q <= 5'h00;
        end
        else
        begin
            case (state_q)
                st_idle:
                begin
                    if (erase_go)
                    begin
                        state_q      <= st_erase;
                        erase_unit_q <= req.addr[`FLASH_ADDR_BITS-1:`UNIT_SHIFT];
                        erase_idx_q  <= 8'h00;
                    end
                end
                st_erase:
                begin
                    erase_idx_q <= erase_idx_q + 8'h01;
                    if (erase_last)
                    begin
                        state_q <= st_idle;
                    end
                end
                default:
                begin
                    state_q <= st_idle;
                end
            endcase
        end
    end

    // ****************************************
    // Array writes
    // ****************************************
    // Erase has priority; program can only clear bits, never set them
    // Reads of the array below see the value from before this edge
    always_ff @(posedge clk_sys)
    begin
        if (busy)
        begin
            mem[{erase_unit_q, erase_idx_q}] <= `ERASED_WORD;
        end
        else if (program_go)
        begin
            mem[addr_word] <= mem[addr_word] & req.wdata;
        end
    end

    // ****************************************
    // Answer
    // ****************************************
    // Done pulses one cycle after a served access or after the last erased word
    // An erase gives no done when taken, only when its unit is finished
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= program_go || read_go || erase_last;
        end
    end

    // Refusal pulses instead of done, never together with it
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            refused_q <= 1'b0;
        end
        else
        begin
            refused_q <= refuse;
        end
    end

    // Read data stands only with done; zero otherwise so stale words never leak
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_q <= '0;
        end
        else if (read_go)
        begin
            rdata_q <= mem[addr_word];
        end
        else
        begin
            rdata_q <= '0;
        end
    end

    // Carrier back to the requester
    assign rsp = '{done: done_q, refused: refused_q, rdata: rdata_q};

    // ****************************************
    // Violation status
    // ****************************************
    // Sticky flag; a new refusal in the clearing cycle wins so no event is lost
    // Software polls it; nothing else in the block reads it
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            violation_q <= 1'b0;
        end
        else if (refuse)
        begin
            violation_q <= 1'b1;
        end
        else if (violation_clear)
        begin
            violation_q <= 1'b0;
        end
    end

endmodule // flash_block_protection

// *** testbench/flash_block_protection_properties.sv ***
// Port checker of the flash access block.
// Assumes the block's defines header is in the include path.
`timescale 1ns/1ps
`include "flash_prot_defines.svh"
module flash_block_protection_properties
    import flash_prot_pkg::*;
#(parameter int REGIONS = `REGION_COUNT)
(
    // Watched ports
    input wire logic               clk_sys,
    input wire logic               rst_n,
    input wire flash_req_type      req,
    input wire flash_rsp_type      rsp,
    input wire logic [2*REGIONS-1:0] prot_map,
    input wire logic               violation_clear,
    input wire logic               violation_q
);
    logic       busy_q;
    logic [1:0] pc;
    logic       tk, ex, lk;
    // Region code of the request; an erase hides later requests
    assign pc = prot_map[{req.addr[14:11], 1'b0} +: 2];
    assign tk = req.valid & ~busy_q;
    assign ex = pc == `PROT_EXEC_ONLY;
    assign lk = ex | pc == `PROT_READ_ONLY;
    always_ff @(posedge clk_sys or negedge rst_n)
        if (!rst_n)
            busy_q <= 1'b0;
        else if (tk & req.op == op_erase & ~lk)
            busy_q <= 1'b1;
        else if (rsp.done)
            busy_q <= 1'b0;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    AST_READ: assert property (tk & req.op == op_read & ~ex |=> rsp.done & ~rsp.refused)
        else $error("read late");
    AST_EXEC: assert property (tk & ex & (req.op == op_read | req.op == op_fetch & req.debug) |=> rsp.refused)
        else $error("exec read served");
    AST_FETCH: assert property (tk & req.op == op_fetch & ~(ex & req.debug) |=> rsp.done)
        else $error("fetch lost");
    AST_LOCK: assert property (tk & lk & (req.op == op_program | req.op == op_erase) |=> rsp.refused & ~rsp.done)
        else $error("locked write");
    AST_PROG: assert property (tk & ~lk & req.op == op_program |=> rsp.done)
        else $error("program lost");
    AST_FLAG: assert property (rsp.refused |-> violation_q)
        else $error("flag missing");
    AST_HOLD: assert property (violation_q & ~violation_clear |=> violation_q)
        else $error("flag dropped");
    AST_ERASE: assert property (tk & ~lk & req.op == op_erase |=> ~rsp.done [*8] ##249 rsp.done)
        else $error("erase time");
endmodule // flash_block_protection_properties
bind flash_block_protection flash_block_protection_properties #(.REGIONS(REGIONS)) chk_u (.clk_sys(clk_sys),
    .rst_n(rst_n), .req(req), .rsp(rsp), .prot_map(prot_map), .violation_clear(violation_clear), .violation_q(violation_q));

// *** testbench/flash_requester.sv ***
// Model of the fetch, data and debug buses.
// Assumes the bench hands it one command per cycle.
`timescale 1ns/1ps
module flash_requester
    import flash_prot_pkg::*;
(
    // Clock and command
    input wire logic          clk_sys,
    input wire flash_req_type cmd,
    // Request out
    output flash_req_type     req
);
    initial req = '0;
    // Idle address and data lines toggle, op and debug hold, so a stale address never looks valid
    always @(posedge clk_sys)
        req <= cmd.valid ? cmd : '{1'b0, req.op, req.debug, ~req.addr, ~req.wdata};
endmodule // flash_requester

// *** testbench/flash_block_protection_bench.sv ***
// Bench of the flash access block, one region of each code.
// Assumes the requester model and the checker.
`timescale 1ns/1ps
`include "flash_prot_defines.svh"
module flash_block_protection_bench
    import flash_prot_pkg::*;
;
    localparam logic [31:0] MAP = 32'he4e4e4e4;
    logic          clk_sys, rst_n, violation_clear, violation_q, rf;
    flash_req_type cmd, req;
    flash_rsp_type rsp;
    logic [31:0]   lf, rd, r0, map;
    logic [14:0]   a;
    logic [1:0]    c;
    int            mismatches, checked, i, n;
    flash_requester host_u (.clk_sys(clk_sys), .cmd(cmd), .req(req));
    flash_block_protection dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .req(req), .rsp(rsp),
        .prot_map(map), .violation_clear(violation_clear), .violation_q(violation_q));
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] nx(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic ref_exp(flash_op_type op, logic d, logic [1:0] k);
        return k == `PROT_EXEC_ONLY && (op != op_fetch || d) || k == `PROT_READ_ONLY && op inside {op_program, op_erase};
    endfunction
    task automatic chk(logic [31:0] got, exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // One request; n counts cycles to the answer, bounded
    task automatic xfer(flash_op_type op, logic d, logic [14:0] ad);
        cmd = '{1'b1, op, d, ad, lf};
        @(posedge clk_sys) #1 cmd.valid = 1'b0;
        for (n = 0; rsp.done !== 1'b1 && rsp.refused !== 1'b1; n++)
        begin
            if (n == 300)
            begin
                mismatches++;
                end_sim;
            end
            @(posedge clk_sys) #1;
        end
        rd = rsp.rdata;
        rf = rsp.refused;
        @(posedge clk_sys) #1;
    endtask
    initial
    begin
        {mismatches, checked, cmd, violation_clear, rst_n, map} = '0;
        lf = 32'he;
        repeat (2) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        // Region i holds code i; random word in its first unit
        for (i = 0; i < 4; i++)
        begin
            lf = nx(lf);
            a = {i[3:0], 1'b0, lf[9:2], 2'b00};
            c = MAP[2*i +: 2];
            // Preload a known word with every region open, then lock the map
            map = '0;
            xfer(op_erase, 1'b0, a);
            xfer(op_program, 1'b0, a);
            chk(rf, 1'b0);
            r0 = lf;
            lf = nx(lf);
            map = MAP;
            // n counts from the requester's latch edge, one cycle before the take
            xfer(op_erase, 1'b0, a);
            chk(rf, ref_exp(op_erase, 1'b0, c));
            chk(n, rf ? 1 : 1 + (1 << `UNIT_SHIFT) / 4);
            xfer(op_read, 1'b0, a);
            chk(rf, ref_exp(op_read, 1'b0, c));
            if (!rf) chk(rd, c == 2'h1 ? r0 : `ERASED_WORD);
            xfer(op_program, 1'b0, a);
            chk(rf, ref_exp(op_program, 1'b0, c));
            xfer(op_erase, 1'b0, a ^ 15'h400);
            xfer(op_fetch, 1'b0, a);
            chk(n, 1);
            chk(rd, c[0] ^ c[1] ? r0 : lf);
            xfer(op_fetch, 1'b1, a);
            chk(rf, ref_exp(op_fetch, 1'b1, c));
        end
        chk(violation_q, 1'b1);
        violation_clear = 1'b1;
        @(posedge clk_sys) #1 violation_clear = 1'b0;
        chk(violation_q, 1'b0);
        end_sim;
    end
endmodule // flash_block_protection_bench
